// file: verilog/vlr_consts.vh
`ifndef VLR_CONSTS_VH
`define VLR_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define VLR_OFS_CONV2_SLEEP_CONTROL 8'h93
`define VLR_OFS_CONV4_VOLTAGE_CODE 8'h94
`define VLR_OFS_CONV4_SLEEP_VOLTAGE_CODE 8'h95
`define VLR_OFS_CONV5_VOLTAGE_CODE 8'h96

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VLR_CODE_MSB 7
`define VLR_CODE_LSB 1
`define VLR_FLAG_BIT 0

// ----------------------------------------------------------------
// reset values (one factory variant; overridable per variant)
// ----------------------------------------------------------------
`define VLR_RST_CONV2_SLEEP_CONTROL 8'h5B
`define VLR_RST_CONV4_VOLTAGE_CODE 8'h28
`define VLR_RST_CONV4_SLEEP_VOLTAGE_CODE 8'h28
`define VLR_RST_CONV5_VOLTAGE_CODE 8'h70

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define VLR_CLK_PERIOD_NS 100
`define VLR_SLEW_STEP_NS 1000
`define VLR_SLEW_STEP_CYC ((`VLR_SLEW_STEP_NS + `VLR_CLK_PERIOD_NS - 1) / `VLR_CLK_PERIOD_NS)

`endif

// file: verilog/vlr_pin_sync.v
`timescale 1ns/1ns

module vlr_pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input wire clk,
	input wire srst,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;

always @(posedge clk) begin
	if (srst) begin
		stage1 <= RESET_VAL;
		stage2 <= RESET_VAL;
		stage3 <= RESET_VAL;
	end else begin
		stage1 <= din;
		stage2 <= stage1;
		stage3 <= stage2;
	end
end

// a level is accepted only once the last two stages agree
genvar b;
generate
	for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
		always @(posedge clk) begin
			if (srst)
				dout[b] <= RESET_VAL[b];
			else if (stage2[b] == stage3[b])
				dout[b] <= stage3[b];
		end
	end
endgenerate

endmodule // vlr_pin_sync

// file: verilog/vlr_regs.v
`timescale 1ns/1ns
`include "vlr_consts.vh"


module vlr_regs #(
	parameter [6:0] DEV_ADDR = 7'h5E,
	parameter SLEEP_PIN_SEL = 0,
	parameter STEP_RANGE_25MV = 0,
	parameter [7:0] RST_CONV2_SLEEP_CONTROL = `VLR_RST_CONV2_SLEEP_CONTROL,
	parameter [7:0] RST_CONV4_VOLTAGE_CODE = `VLR_RST_CONV4_VOLTAGE_CODE,
	parameter [7:0] RST_CONV4_SLEEP_VOLTAGE_CODE = `VLR_RST_CONV4_SLEEP_VOLTAGE_CODE,
	parameter [7:0] RST_CONV5_VOLTAGE_CODE = `VLR_RST_CONV5_VOLTAGE_CODE
) (
	input wire clk,
	input wire srst,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	input wire first_sleep_enable_input,
	input wire second_sleep_enable_input,
	input wire [6:0] conv2_normal_code,
	output reg [6:0] conv2_target_code,
	output reg conv2_in_sleep,
	output reg [6:0] conv4_applied_code,
	output reg conv4_slewing,
	output reg conv4_passive_decay,
	output reg [6:0] conv4_sleep_code,
	output reg [6:0] conv5_applied_code,
	output reg conv5_slewing,
	output reg conv5_passive_decay,
	output reg step_range_25mv
);

// ----------------------------------------------------------------
// constants
// ----------------------------------------------------------------
localparam ST_IDLE = 4'h0;
localparam ST_ADDR = 4'h1;
localparam ST_AACK = 4'h2;
localparam ST_PTR = 4'h3;
localparam ST_PACK = 4'h4;
localparam ST_WDATA = 4'h5;
localparam ST_WACK = 4'h6;
localparam ST_RDATA = 4'h7;
localparam ST_RACK = 4'h8;

localparam integer SLEW_INT = `VLR_SLEW_STEP_CYC;
localparam [7:0] SLEW_CYC = SLEW_INT[7:0];

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
wire scl_s;
wire sda_s;
wire sleep1_s;
wire sleep2_s;

vlr_pin_sync #(.WIDTH(4), .RESET_VAL(4'hF)) u_sync (
	.clk(clk),
	.srst(srst),
	.din({scl_in, sda_in, first_sleep_enable_input, second_sleep_enable_input}),
	.dout({scl_s, sda_s, sleep1_s, sleep2_s})
);

reg scl_q;
reg sda_q;
wire scl_rise = scl_s & ~scl_q;
wire scl_fall = ~scl_s & scl_q;
wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;

// ----------------------------------------------------------------
// register file
// ----------------------------------------------------------------
reg [7:0] conv2_sleep_control;
reg [7:0] conv4_voltage_code;
reg [7:1] conv4_sleep_bits;
reg [7:0] conv5_voltage_code;
reg wr_pulse;
reg [7:0] wr_addr;
reg [7:0] wr_data;
reg [7:0] pointer;
reg [7:0] rd_data;

always @(posedge clk) begin
	if (srst) begin
		conv2_sleep_control <= RST_CONV2_SLEEP_CONTROL;
		conv4_voltage_code <= RST_CONV4_VOLTAGE_CODE;
		conv4_sleep_bits <= RST_CONV4_SLEEP_VOLTAGE_CODE[7:1];
		conv5_voltage_code <= RST_CONV5_VOLTAGE_CODE;
	end else if (wr_pulse) begin
		case (wr_addr)
			`VLR_OFS_CONV2_SLEEP_CONTROL: conv2_sleep_control <= wr_data;
			`VLR_OFS_CONV4_VOLTAGE_CODE: conv4_voltage_code <= wr_data;
			`VLR_OFS_CONV4_SLEEP_VOLTAGE_CODE: conv4_sleep_bits <= wr_data[7:1];
			`VLR_OFS_CONV5_VOLTAGE_CODE: conv5_voltage_code <= wr_data;
			default: ;
		endcase
	end
end

// unmapped offsets read as zero and swallow writes
always @* begin
	case (pointer)
		`VLR_OFS_CONV2_SLEEP_CONTROL: rd_data = conv2_sleep_control;
		`VLR_OFS_CONV4_VOLTAGE_CODE: rd_data = conv4_voltage_code;
		`VLR_OFS_CONV4_SLEEP_VOLTAGE_CODE: rd_data = {conv4_sleep_bits, 1'b0};
		`VLR_OFS_CONV5_VOLTAGE_CODE: rd_data = conv5_voltage_code;
		default: rd_data = 8'h00;
	endcase
end

// ----------------------------------------------------------------
// two-wire serial slave
// ----------------------------------------------------------------
reg [3:0] state;
reg [3:0] bit_cnt;
reg [7:0] shift;
reg [7:0] tx;
reg rd_mode;
reg sda_drive;

assign sda_out = 1'b0;
assign sda_oe = sda_drive;

always @(posedge clk) begin
	if (srst) begin
		scl_q <= 1'b1;
		sda_q <= 1'b1;
		state <= ST_IDLE;
		bit_cnt <= 4'h0;
		shift <= 8'h00;
		tx <= 8'h00;
		rd_mode <= 1'b0;
		sda_drive <= 1'b0;
		pointer <= 8'h00;
		wr_pulse <= 1'b0;
		wr_addr <= 8'h00;
		wr_data <= 8'h00;
	end else begin
		scl_q <= scl_s;
		sda_q <= sda_s;
		wr_pulse <= 1'b0;
		if (bus_start) begin
			state <= ST_ADDR;
			bit_cnt <= 4'h0;
			sda_drive <= 1'b0;
		end else if (bus_stop) begin
			state <= ST_IDLE;
			sda_drive <= 1'b0;
		end else begin
			case (state)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise) begin
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						if (state == ST_ADDR) begin
							if (shift[7:1] == DEV_ADDR) begin
								sda_drive <= 1'b1;
								rd_mode <= shift[0];
								state <= ST_AACK;
							end else begin
								state <= ST_IDLE;
							end
						end else if (state == ST_PTR) begin
							pointer <= shift;
							sda_drive <= 1'b1;
							state <= ST_PACK;
						end else begin
							wr_pulse <= 1'b1;
							wr_addr <= pointer;
							wr_data <= shift;
							sda_drive <= 1'b1;
							state <= ST_WACK;
						end
					end
				end
				ST_AACK, ST_PACK, ST_WACK: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						sda_drive <= 1'b0;
						if (state == ST_AACK && rd_mode) begin
							tx <= rd_data;
							sda_drive <= ~rd_data[7];
							state <= ST_RDATA;
						end else if (state == ST_AACK) begin
							state <= ST_PTR;
						end else begin
							if (state == ST_WACK)
								pointer <= pointer + 8'h01;
							state <= ST_WDATA;
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h7) begin
							sda_drive <= 1'b0;
							state <= ST_RACK;
						end else begin
							tx <= {tx[6:0], 1'b0};
							sda_drive <= ~tx[6];
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				ST_RACK: begin
					// a not-acknowledge ends the read; the master then stops
					if (scl_rise) begin
						if (sda_s)
							state <= ST_IDLE;
						else
							pointer <= pointer + 8'h01;
					end else if (scl_fall) begin
						tx <= rd_data;
						sda_drive <= ~rd_data[7];
						bit_cnt <= 4'h0;
						state <= ST_RDATA;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
end

// ----------------------------------------------------------------
// converter two sleep selection
// ----------------------------------------------------------------
wire sleep_pin = (SLEEP_PIN_SEL != 0) ? sleep2_s : sleep1_s;
wire use_sleep = conv2_sleep_control[`VLR_FLAG_BIT] & ~sleep_pin;

always @(posedge clk) begin
	if (srst) begin
		conv2_target_code <= 7'h00;
		conv2_in_sleep <= 1'b0;
		conv4_sleep_code <= 7'h00;
		step_range_25mv <= 1'b0;
	end else begin
		conv2_in_sleep <= use_sleep;
		if (use_sleep)
			conv2_target_code <= conv2_sleep_control[7:1];
		else
			conv2_target_code <= conv2_normal_code;
		conv4_sleep_code <= conv4_sleep_bits;
		step_range_25mv <= (STEP_RANGE_25MV != 0);
	end
end

// ----------------------------------------------------------------
// converters four and five: slewed or passive descent
// ----------------------------------------------------------------
wire [15:0] vc_all = {conv5_voltage_code, conv4_voltage_code};
wire [15:0] rst_all = {RST_CONV5_VOLTAGE_CODE, RST_CONV4_VOLTAGE_CODE};
wire [13:0] cur_all;
wire [1:0] slew_all;
wire [1:0] passive_all;

genvar c;
generate
	for (c = 0; c < 2; c = c + 1) begin : g_conv
		wire [6:0] req = vc_all[8*c+7:8*c+1];
		wire decay = vc_all[8*c];
		reg [6:0] cur;
		reg slew;
		reg passive;
		reg [7:0] tmr;
		// one process per converter owns its state; the vectors only gather it
		assign cur_all[7*c+6:7*c] = cur;
		assign slew_all[c] = slew;
		assign passive_all[c] = passive;
		always @(posedge clk) begin
			if (srst) begin
				cur <= rst_all[8*c+7:8*c+1];
				slew <= 1'b0;
				passive <= 1'b0;
				tmr <= 8'h00;
			end else if (req >= cur) begin
				// rising or settled: no descent control needed
				cur <= req;
				slew <= 1'b0;
				if (req > cur)
					passive <= 1'b0;
				tmr <= 8'h00;
			end else if (decay) begin
				// regulator stops sinking; fall rate set by load and capacitance
				cur <= req;
				slew <= 1'b0;
				passive <= 1'b1;
				tmr <= 8'h00;
			end else begin
				slew <= 1'b1;
				passive <= 1'b0;
				if (tmr == SLEW_CYC - 8'h01) begin
					tmr <= 8'h00;
					cur <= cur - 7'h01;
				end else begin
					tmr <= tmr + 8'h01;
				end
			end
		end
	end
endgenerate

always @* begin
	conv4_applied_code = cur_all[6:0];
	conv5_applied_code = cur_all[13:7];
	conv4_slewing = slew_all[0];
	conv5_slewing = slew_all[1];
	conv4_passive_decay = passive_all[0];
	conv5_passive_decay = passive_all[1];
end

endmodule // vlr_regs

// file: verif/vlr_regs_asserts.sv
`timescale 1ns/1ns

module vlr_regs_chk #(
	parameter STEP_RANGE_25MV = 0
) (
	input wire clk,
	input wire srst,
	input wire scl_in,
	input wire sda_oe,
	input wire first_sleep_enable_input,
	input wire [6:0] conv2_normal_code,
	input wire [6:0] conv2_target_code,
	input wire conv2_in_sleep,
	input wire [6:0] conv4_applied_code,
	input wire conv4_slewing,
	input wire conv4_passive_decay,
	input wire [6:0] conv5_applied_code,
	input wire conv5_slewing,
	input wire conv5_passive_decay,
	input wire step_range_25mv
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_norm;
		!$past(srst) && !conv2_in_sleep |-> conv2_target_code == $past(conv2_normal_code);
	endproperty
	a_norm: assert property (p_norm) else $error("normal code not followed");
	// pin high long enough to pass the syncs must leave sleep
	property p_pin;
		first_sleep_enable_input [*8] |-> !conv2_in_sleep;
	endproperty
	a_pin: assert property (p_pin) else $error("sleep with pin high");
	property p_slew4;
		conv4_slewing && $past(conv4_slewing) && $changed(conv4_applied_code)
		|-> conv4_applied_code == $past(conv4_applied_code) - 7'h01
		##1 $stable(conv4_applied_code) [*8];
	endproperty
	a_slew4: assert property (p_slew4) else $error("bad slew step");
	property p_slew5;
		conv5_slewing && $past(conv5_slewing) && $changed(conv5_applied_code)
		|-> conv5_applied_code == $past(conv5_applied_code) - 7'h01
		##1 $stable(conv5_applied_code) [*8];
	endproperty
	a_slew5: assert property (p_slew5) else $error("bad slew step");
	property p_dec4;
		$rose(conv4_passive_decay)
		|-> conv4_applied_code < $past(conv4_applied_code) && !conv4_slewing;
	endproperty
	a_dec4: assert property (p_dec4) else $error("bad passive drop");
	property p_dec5;
		$rose(conv5_passive_decay)
		|-> conv5_applied_code < $past(conv5_applied_code) && !conv5_slewing;
	endproperty
	a_dec5: assert property (p_dec5) else $error("bad passive drop");
	property p_oe;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	a_oe: assert property (p_oe) else $error("data changed with clock high");
	property p_rng;
		!$past(srst) |-> step_range_25mv == (STEP_RANGE_25MV != 0);
	endproperty
	a_rng: assert property (p_rng) else $error("wrong step range");
	c_slew: cover property ($rose(conv4_slewing));
	c_dec: cover property ($rose(conv5_passive_decay));
	c_slp: cover property ($rose(conv2_in_sleep));
endmodule // vlr_regs_chk

bind vlr_regs vlr_regs_chk #(.STEP_RANGE_25MV(STEP_RANGE_25MV)) u_chk (
	.clk(clk), .srst(srst), .scl_in(scl_in), .sda_oe(sda_oe),
	.first_sleep_enable_input(first_sleep_enable_input),
	.conv2_normal_code(conv2_normal_code), .conv2_target_code(conv2_target_code),
	.conv2_in_sleep(conv2_in_sleep), .conv4_applied_code(conv4_applied_code),
	.conv4_slewing(conv4_slewing), .conv4_passive_decay(conv4_passive_decay),
	.conv5_applied_code(conv5_applied_code), .conv5_slewing(conv5_slewing),
	.conv5_passive_decay(conv5_passive_decay), .step_range_25mv(step_range_25mv));

// file: verif/vlr_host.sv
`timescale 1ns/1ns

module vlr_host (
	input wire clk,
	input wire sda,
	output reg scl,
	output reg pull
);
	// ----------------------------------------
	// serial master, quarter bit of 8 cycles
	// ----------------------------------------
	reg [6:0] adr;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
		adr = 7'h5E;
	end
	task q;
		repeat (8) @(posedge clk);
	endtask
	task st;
		begin
			pull <= 1'b0;
			q;
			scl <= 1'b1;
			q;
			pull <= 1'b1;
			q;
			scl <= 1'b0;
			q;
		end
	endtask
	task sp;
		begin
			pull <= 1'b1;
			q;
			scl <= 1'b1;
			q;
			pull <= 1'b0;
			q;
		end
	endtask
	// data only moves while the clock is low
	task bt(input v, output r);
		begin
			pull <= ~v;
			q;
			scl <= 1'b1;
			q;
			r = sda;
			q;
			scl <= 1'b0;
			q;
		end
	endtask
	task by(input [7:0] d, output [7:0] r);
		integer i;
		reg b;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				bt(d[i], b);
				r[i] = b;
			end
		end
	endtask
	task wr(input [7:0] o, input [7:0] d, output ok);
		reg [7:0] x;
		reg a, b, c;
		begin
			st;
			by({adr, 1'b0}, x);
			bt(1'b1, a);
			by(o, x);
			bt(1'b1, b);
			by(d, x);
			bt(1'b1, c);
			sp;
			ok = ~(a | b | c);
		end
	endtask
	task rd(input [7:0] o, output [7:0] d);
		reg [7:0] x;
		reg a;
		begin
			st;
			by({adr, 1'b0}, x);
			bt(1'b1, a);
			by(o, x);
			bt(1'b1, a);
			st;
			by({adr, 1'b1}, x);
			bt(1'b1, a);
			by(8'hFF, d);
			bt(1'b1, a);
			sp;
		end
	endtask
endmodule // vlr_host

// file: verif/vlr_regs_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks = total_checks + 1; if ((a) !== (e)) begin \
	n_fail = n_fail + 1; $display("wrong value at %0t: %h %h", $time, a, e); end end

module vlr_regs_bench;
	reg clk;
	reg srst;
	reg pin1;
	reg pin2;
	reg [6:0] norm;
	reg [7:0] d;
	reg ok;
	integer i;
	integer n_fail;
	integer total_checks;
	wire scl, pull, sda, oe, slp, sl4, pd4, sl5, pd5, rng;
	wire [6:0] t2, a4, s4, a5;
	// open drain line with pull-up
	assign sda = ~(pull | oe);
	vlr_host h (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
	vlr_regs dut (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe(oe), .first_sleep_enable_input(pin1), .second_sleep_enable_input(pin2),
		.conv2_normal_code(norm), .conv2_target_code(t2), .conv2_in_sleep(slp),
		.conv4_applied_code(a4), .conv4_slewing(sl4), .conv4_passive_decay(pd4),
		.conv4_sleep_code(s4), .conv5_applied_code(a5), .conv5_slewing(sl5),
		.conv5_passive_decay(pd5), .step_range_25mv(rng));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task end_sim;
		begin
			if (n_fail == 0 && total_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_rst;
		begin
			`CHK(a4, 7'h14)
			`CHK(a5, 7'h38)
			`CHK(rng, 1'b0)
			h.rd(8'h93, d);
			`CHK(d, 8'h5B)
			h.rd(8'h95, d);
			`CHK(d, 8'h28)
			h.rd(8'h96, d);
			`CHK(d, 8'h70)
		end
	endtask
	task t_c2;
		begin
			pin1 <= 1'b0;
			repeat (10) @(posedge clk);
			`CHK(t2, 7'h2D)
			`CHK(slp, 1'b1)
			pin1 <= 1'b1;
			pin2 <= 1'b0;
			norm <= 7'h33;
			repeat (10) @(posedge clk);
			`CHK(t2, 7'h33)
			pin1 <= 1'b0;
			h.wr(8'h93, 8'h5A, ok);
			`CHK(t2, 7'h33)
			h.rd(8'h93, d);
			`CHK(d, 8'h5A)
		end
	endtask
	task t_c4;
		begin
			h.wr(8'h94, 8'h60, ok);
			`CHK(a4, 7'h30)
			h.wr(8'h94, 8'h20, ok);
			`CHK(sl4, 1'b1)
			i = 0;
			while (sl4 === 1'b1 && i < 400) begin
				@(negedge clk);
				i = i + 1;
			end
			`CHK(a4, 7'h10)
			h.wr(8'h94, 8'h11, ok);
			`CHK({a4, pd4, sl4}, 9'h022)
			h.wr(8'h94, 8'h60, ok);
			`CHK({a4, pd4}, 8'h60)
			h.wr(8'h95, 8'hFF, ok);
			`CHK(s4, 7'h7F)
			h.rd(8'h95, d);
			`CHK(d, 8'hFE)
		end
	endtask
	task t_c5;
		begin
			h.wr(8'h96, 8'h11, ok);
			`CHK({a5, pd5}, 8'h11)
			h.wr(8'h96, 8'h02, ok);
			`CHK({pd5, sl5}, 2'h1)
			repeat (200) @(posedge clk);
			`CHK(a5, 7'h01)
		end
	endtask
	task t_bad;
		begin
			h.adr = 7'h5F;
			h.wr(8'h94, 8'h00, ok);
			`CHK(ok, 1'b0)
			h.adr = 7'h5E;
			`CHK(a4, 7'h30)
			h.wr(8'h97, 8'hAA, ok);
			h.rd(8'h97, d);
			`CHK(d, 8'h00)
		end
	endtask
	initial begin
		n_fail = 0;
		total_checks = 0;
		srst = 1'b1;
		pin1 = 1'b1;
		pin2 = 1'b1;
		norm = 7'h40;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (10) @(posedge clk);
		t_rst;
		t_c2;
		t_c4;
		t_c5;
		t_bad;
		end_sim;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_fail = n_fail + 1;
		end_sim;
	end
endmodule // vlr_regs_bench
